// ==== monitor_status_alert_aggregator.sv ====
// Function
// - lock ignores config writes
// - inverted channel reads 0xff minus code
// - trip mode blocks ch4 inversion
// - ch3 voltage mode overrides diode mode
// - ch1,2 alike; trip mode blocks ch1
// - status bits alert, shutdown flags excepted
// - read clears gone bits, alert releases
// - loader flag alerts unless globally masked
// - die flag never alerts, clears on read when gone
// - critical summary ORs critical status
// - pin summary follows pin status
// - fan/high/low/fault summaries follow registers
// - summary read keeps channel bits
// - status read clears gone conditions only
// - voltage channels ignore diode faults
// - critical status holds linked channel
// - hardware trip flag at threshold
// - fan bits clear on read when gone
// - watchdog after four seconds unprogrammed
// - drive limit flags, maskable
// - overcurrent flag after two seconds
// - global mask stops alert
// - channel enable gates alert only
`timescale 1ns/1ps
`default_nettype none

module monitor_status_alert_aggregator
   import monitor_alert_pkg::*;
#(
   parameter longint TICK_CYCLES_P    = TICK_CYCLES,
   parameter longint WATCHDOG_TICKS_P = WATCHDOG_TIME_MS * 1000 / TICK_TIME_US,
   parameter longint OVERCUR_TICKS_P  = OVERCUR_TIME_MS * 1000 / TICK_TIME_US
) (
   input  wire logic             clk_sys_i,          // system clock
   input  wire logic             reset_i,            // async reset, high
   input  wire logic [7:0]       reg_addr_i,         // register offset
   input  wire logic             reg_wr_i,           // write strobe
   input  wire logic [7:0]       reg_wdata_i,        // write data
   input  wire logic             reg_rd_i,           // read strobe
   output var  logic [7:0]       reg_rdata_o,        // read data
   output var  logic             reg_rvalid_o,       // read data valid
   input  wire logic             config_lock_i,      // software lock in force
   input  wire logic             trip_threshold_pin_i, // trip pin sets ch1 crit
   input  wire logic             antiparallel_diode_en_i, // config bit
   input  wire alert_enable_type alert_en_i,         // enables and mask
   input  wire monitor_cond_type cond_i,             // error conditions
   input  wire logic [3:0][7:0]  vin_raw_i,          // measured codes ch4..1
   output var  logic [3:0][7:0]  vin_value_o,        // presented codes
   output var  logic [2:0]       voltage_mode_o,     // ch3..ch1 voltage mode
   output var  logic             antiparallel_eff_o, // effective diode mode
   output var  logic             shutdown_out_n_o,   // shutdown, active low
   output var  logic             alert_n_o           // alert, active low
);

   // ************
   // helpers
   // ************

   // sticky bits: a live condition always wins over the read clear
   function automatic logic [7:0] rc_next(input logic [7:0] q,
                                          input logic [7:0] cond,
                                          input logic       rd);
      logic [7:0] keep;

      // a read drops only bits whose condition has gone
      keep = rd ? (q & cond) : q;

      return keep | cond;
   endfunction : rc_next


   // ************
   // register access decode
   // ************

   wire logic rd_crit  = reg_rd_i && (reg_addr_i == ADDR_CRIT_STATUS);
   wire logic rd_sum   = reg_rd_i && (reg_addr_i == ADDR_INT_SUMMARY);
   wire logic rd_high  = reg_rd_i && (reg_addr_i == ADDR_HIGH_STATUS);
   wire logic rd_low   = reg_rd_i && (reg_addr_i == ADDR_LOW_STATUS);
   wire logic rd_fault = reg_rd_i && (reg_addr_i == ADDR_FAULT_STAT);
   wire logic rd_fan   = reg_rd_i && (reg_addr_i == ADDR_FAN_STATUS);

   wire logic wr_vch   = reg_wr_i && (reg_addr_i == ADDR_VCH_CONFIG);

   // ************
   // voltage channel configuration
   // ************

   logic [7:0] vch_q;
   logic [7:0] vch_d;

   // bits blocked by trip pin mode are forced clear on every unlocked write
   wire logic [7:0] vch_allowed = trip_threshold_pin_i ?
                                  (VCH_WRITABLE & ~VCH_TRIP_BLOCK) :
                                  VCH_WRITABLE;
   // a write while locked leaves the register as it is
   assign vch_d = (wr_vch && !config_lock_i) ?
                  (reg_wdata_i & vch_allowed) : vch_q;

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         vch_q <= RESET_VCH_CONFIG;
      end else begin
         vch_q <= vch_d;
      end
   end


   wire logic [2:0] vmode = {vch_q[VCH_CH3_MODE], vch_q[VCH_CH2_MODE],
                             vch_q[VCH_CH1_MODE]};

   wire logic [3:0] vinv  = {vch_q[VCH_CH4_INV], vch_q[VCH_CH3_INV],
                             vch_q[VCH_CH2_INV], vch_q[VCH_CH1_INV]};

   // presented codes: inverted channels read as full scale minus code
   logic [3:0][7:0] vin_value_d;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         vin_value_d[i] = vinv[i] ? (8'hff - vin_raw_i[i]) : vin_raw_i[i];
      end
   end

   // ************
   // millisecond tick and fan timers
   // ************

   // one shared tick keeps the second-range counters narrow
   logic [31:0] tick_cnt_q;
   logic        tick_q;

   wire  logic  tick_wrap = (tick_cnt_q == 32'(TICK_CYCLES_P - 1));


   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q     <= 1'b0;
      end else begin
         tick_cnt_q <= tick_wrap ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
         tick_q     <= tick_wrap;
      end
   end

   // watchdog runs from reset until the host programs the fans
   // limitation: never rearms before the next reset
   logic [15:0] wdog_cnt_q;
   logic        wdog_done_q;

   wire  logic  wdog_expire = tick_q && !wdog_done_q &&
                              (wdog_cnt_q == 16'(WATCHDOG_TICKS_P - 1));

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         wdog_cnt_q  <= 16'h0000;
         wdog_done_q <= 1'b0;
      end else if (cond_i.fan_programmed || wdog_expire) begin
         wdog_done_q <= 1'b1;
      end else if (tick_q && !wdog_done_q) begin
         wdog_cnt_q <= wdog_cnt_q + 16'h0001;
      end
   end

   // overcurrent must persist past the window before it is flagged
   // one quiet cycle restarts the window
   logic [15:0] ocur_cnt_q;

   wire  logic  ocur_long = (ocur_cnt_q > 16'(OVERCUR_TICKS_P));

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         ocur_cnt_q <= 16'h0000;
      end else if (!cond_i.overcurrent) begin
         ocur_cnt_q <= 16'h0000;
      end else if (tick_q && !ocur_long) begin
         ocur_cnt_q <= ocur_cnt_q + 16'h0001;
      end
   end

   // ************
   // status conditions
   // ************

   // diode faults on channels 1..3 vanish while in voltage mode
   wire logic [7:0] fault_cond = {3'b000,
                                  cond_i.fault & {1'b1, ~vmode}, 1'b0};

   wire logic [7:0] high_cond  = {2'b00, cond_i.high};
   wire logic [7:0] low_cond   = {2'b00, cond_i.low};

   // only channels linked to shutdown may record a critical event
   wire logic [7:0] crit_cond  = {cond_i.hw_trip, 2'b00,
                                  cond_i.crit & cond_i.crit_link};
   wire logic [7:0] fan_cond   = {wdog_expire,
                                  cond_i.drive_limit,
                                  ocur_long,
                                  cond_i.spinup_timeout[1],
                                  cond_i.stalled[1],
                                  cond_i.spinup_timeout[0],
                                  cond_i.stalled[0]};

   // ************
   // error status registers
   // ************

   logic [7:0] crit_q;
   logic [7:0] high_q;
   logic [7:0] low_q;
   logic [7:0] fault_q;
   logic [7:0] fan_q;
   logic       loader_q;
   logic       die_q;

   // each register clears only on its own read, never on a summary read
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         crit_q  <= RESET_STATUS;
         high_q  <= RESET_STATUS;
         low_q   <= RESET_STATUS;
         fault_q <= RESET_STATUS;
         fan_q   <= RESET_STATUS;
      end else begin
         crit_q  <= rc_next(crit_q, crit_cond, rd_crit);
         high_q  <= rc_next(high_q, high_cond, rd_high);
         low_q   <= rc_next(low_q, low_cond, rd_low);
         fault_q <= rc_next(fault_q, fault_cond, rd_fault);
         fan_q   <= rc_next(fan_q, fan_cond, rd_fan);
      end
   end

   // flags owned by the summary register itself
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         loader_q <= 1'b0;
         die_q    <= 1'b0;
      end else begin
         loader_q <= cond_i.loader_error | (loader_q & ~rd_sum);
         die_q    <= cond_i.die_shutdown |
                     (die_q & ~(rd_sum & ~cond_i.die_shutdown));
      end
   end

   // summary bits below the loader and die flags are live ORs, so they fall with their sources
   wire logic [7:0] summary;

   assign summary[SUM_LOADER] = loader_q;
   assign summary[SUM_DIE]    = die_q;
   assign summary[SUM_CRIT]   = |crit_q;
   assign summary[SUM_GPIO]   = cond_i.gpio_any;
   assign summary[SUM_FAN]    = |fan_q;
   assign summary[SUM_HIGH]   = |high_q;
   assign summary[SUM_LOW]    = |low_q;
   assign summary[SUM_FAULT]  = |fault_q;

   // ************
   // alert and shutdown
   // ************

   wire logic [5:0] ch_en = alert_en_i.chan_en;

   // fault bits map ext4..ext1 onto enables ext4..ext1
   wire logic fault_alert = |(fault_q[4:1] & ch_en[4:1]);
   wire logic hl_alert    = |((high_q[5:0] | low_q[5:0]) & ch_en);

   // hardware trip flag is left out, it never alerts
   wire logic crit_alert  = |(crit_q[4:0] & ch_en[4:0]);
   wire logic fan_alert   =
      fan_q[FAN_WATCH] | fan_q[FAN_SHORT] |
      (fan_q[FAN_DRV2]  & alert_en_i.fan_stall_en[1]) |
      (fan_q[FAN_DRV1]  & alert_en_i.fan_stall_en[0]) |
      (fan_q[FAN2_SPINUP_TIMEOUT] & alert_en_i.fan_spin_en[1])  |
      (fan_q[FAN2_STALLED] & alert_en_i.fan_stall_en[1]) |
      (fan_q[FAN1_SPINUP_TIMEOUT] & alert_en_i.fan_spin_en[0])  |
      (fan_q[FAN1_STALLED] & alert_en_i.fan_stall_en[0]);

   // die shutdown flag deliberately absent; loader error has no enable
   wire logic alert_any = loader_q | crit_alert | summary[SUM_GPIO] |
                          fan_alert | hl_alert | fault_alert;
   wire logic alert_d   = alert_any && !alert_en_i.alert_mask;

   // shutdown tracks live conditions, released as soon as they fall
   wire logic shutdown_d = (|(cond_i.crit & cond_i.crit_link)) |
                           cond_i.hw_trip | cond_i.die_shutdown;

   // ************
   // read data
   // ************

   // data is sampled before the clear lands, so the read sees the event
   logic [7:0] rdata_d;

   always_comb begin
      case (reg_addr_i)
         ADDR_CRIT_STATUS: rdata_d = crit_q;
         ADDR_VCH_CONFIG:  rdata_d = vch_q;
         ADDR_INT_SUMMARY: rdata_d = summary;
         ADDR_HIGH_STATUS: rdata_d = high_q;
         ADDR_LOW_STATUS:  rdata_d = low_q;
         ADDR_FAULT_STAT:  rdata_d = fault_q;
         ADDR_FAN_STATUS:  rdata_d = fan_q;
         // unmapped offsets read as zero
         default:          rdata_d = READ_UNMAPPED;
      endcase
   end

   // ************
   // output registers
   // ************

   // every pin leaves from a flop, free of decode glitches
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         reg_rdata_o        <= READ_UNMAPPED;
         reg_rvalid_o       <= 1'b0;
         vin_value_o        <= '0;
         voltage_mode_o     <= 3'b000;
         antiparallel_eff_o <= 1'b0;
         shutdown_out_n_o   <= 1'b1;
         alert_n_o          <= 1'b1;
      end else begin
         // read port
         reg_rdata_o        <= reg_rd_i ? rdata_d : reg_rdata_o;
         reg_rvalid_o       <= reg_rd_i;
         // voltage channels
         vin_value_o        <= vin_value_d;
         voltage_mode_o     <= vmode;
         antiparallel_eff_o <= antiparallel_diode_en_i && !vmode[2];
         // pins, both active low
         shutdown_out_n_o   <= !shutdown_d;
         alert_n_o          <= !alert_d;
      end
   end

endmodule : monitor_status_alert_aggregator

`default_nettype wire

// ==== monitor_alert_pkg.sv ====
// ************
// register map and shared types
// ************
package monitor_alert_pkg;

   // register offsets
   localparam logic [7:0] ADDR_CRIT_STATUS = 8'h1f;
   localparam logic [7:0] ADDR_VCH_CONFIG  = 8'h22;
   localparam logic [7:0] ADDR_INT_SUMMARY = 8'h23;
   localparam logic [7:0] ADDR_HIGH_STATUS = 8'h24;
   localparam logic [7:0] ADDR_LOW_STATUS  = 8'h25;
   localparam logic [7:0] ADDR_FAULT_STAT  = 8'h26;
   localparam logic [7:0] ADDR_FAN_STATUS  = 8'h27;

   // reset values
   localparam logic [7:0] RESET_STATUS     = 8'h00;
   localparam logic [7:0] RESET_VCH_CONFIG = 8'h00;
   localparam logic [7:0] READ_UNMAPPED    = 8'h00;

   // voltage channel config fields
   localparam int VCH_CH4_INV  = 6;
   localparam int VCH_CH3_MODE = 5;
   localparam int VCH_CH3_INV  = 4;
   localparam int VCH_CH2_MODE = 3;
   localparam int VCH_CH2_INV  = 2;
   localparam int VCH_CH1_MODE = 1;
   localparam int VCH_CH1_INV  = 0;
   // bits that may ever hold a one (bit 7 reserved)
   localparam logic [7:0] VCH_WRITABLE   = 8'h7f;
   // bits blocked while the trip pin sets the channel 1 critical limit
   localparam logic [7:0] VCH_TRIP_BLOCK = 8'h43;

   // summary register fields
   localparam int SUM_LOADER = 7;
   localparam int SUM_DIE    = 6;
   localparam int SUM_CRIT   = 5;
   localparam int SUM_GPIO   = 4;
   localparam int SUM_FAN    = 3;
   localparam int SUM_HIGH   = 2;
   localparam int SUM_LOW    = 1;
   localparam int SUM_FAULT  = 0;

   // critical status fields
   localparam int CRIT_HWTRIP = 7;

   // fan status fields
   localparam int FAN_WATCH   = 7;
   localparam int FAN_DRV2    = 6;
   localparam int FAN_DRV1    = 5;
   localparam int FAN_SHORT   = 4;
   localparam int FAN2_SPINUP_TIMEOUT   = 3;
   localparam int FAN2_STALLED  = 2;
   localparam int FAN1_SPINUP_TIMEOUT   = 1;
   localparam int FAN1_STALLED  = 0;

   // timing
   localparam longint CLK_FREQ_HZ     = 250_000_000;
   localparam longint TICK_TIME_US    = 1000;
   localparam longint TICK_CYCLES     = CLK_FREQ_HZ / 1_000_000 * TICK_TIME_US;
   localparam longint WATCHDOG_TIME_MS = 4000;
   localparam longint OVERCUR_TIME_MS  = 2000;

   // error conditions presented by the measurement and fan logic
   typedef struct packed {
      logic [5:0] high;          // volt4, ext4..ext1, internal
      logic [5:0] low;           // volt4, ext4..ext1, internal
      logic [3:0] fault;         // ext4..ext1
      logic [4:0] crit;          // ext4..ext1, internal over critical limit
      logic [4:0] crit_link;     // channel linked to shutdown output
      logic       hw_trip;       // hardware channel at or over trip level
      logic       die_shutdown;  // internal thermal shutdown tripped
      logic       loader_error;  // config memory loader error pulse
      logic       gpio_any;      // any pin status bit set
      logic [1:0] drive_limit;   // fan2, fan1 cannot reach target
      logic [1:0] spinup_timeout;// fan2, fan1
      logic [1:0] stalled;       // fan2, fan1
      logic       overcurrent;   // high side driver overcurrent level
      logic       fan_programmed;// host wrote fan drive settings (pulse)
   } monitor_cond_type;

   // interrupt enables held elsewhere in the device
   typedef struct packed {
      logic       alert_mask;      // global alert mask
      logic [5:0] chan_en;         // volt4, ext4..ext1, internal
      logic [1:0] fan_spin_en;     // fan2, fan1
      logic [1:0] fan_stall_en;    // fan2, fan1 (also drive limit)
   } alert_enable_type;

endpackage : monitor_alert_pkg

// ==== status_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************
// port checker
// ************
module status_monitor
   import monitor_alert_pkg::*;
(
   input wire logic             clk_sys_i,               // clock
   input wire logic             reset_i,                 // reset
   input wire logic [7:0]       reg_addr_i,              // offset
   input wire logic             reg_wr_i,                // write
   input wire logic [7:0]       reg_wdata_i,             // wdata
   input wire logic             reg_rd_i,                // read
   input wire logic [7:0]       reg_rdata_o,             // rdata
   input wire logic             reg_rvalid_o,            // rvalid
   input wire logic             config_lock_i,           // lock
   input wire logic             trip_threshold_pin_i,    // trip mode
   input wire logic             antiparallel_diode_en_i, // diode mode
   input wire alert_enable_type alert_en_i,              // enables
   input wire monitor_cond_type cond_i,                  // conditions
   input wire logic [3:0][7:0]  vin_raw_i,               // raw codes
   input wire logic [3:0][7:0]  vin_value_o,             // presented codes
   input wire logic [2:0]       voltage_mode_o,          // voltage modes
   input wire logic             antiparallel_eff_o,      // effective diode
   input wire logic             shutdown_out_n_o,        // shutdown
   input wire logic             alert_n_o                // alert
);
   // a write that reaches the voltage config, lock aside
   wire logic cfg_wr = reg_wr_i && reg_addr_i == ADDR_VCH_CONFIG;
   wire logic sum_rd = reg_rd_i && reg_addr_i == ADDR_INT_SUMMARY;

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   // ************
   // properties
   // ************
   mask_blocks_a: assert property (alert_en_i.alert_mask |=> alert_n_o)
      else $error("alert asserted while masked");
   die_shutdown_a: assert property (cond_i.die_shutdown |=> !shutdown_out_n_o)
      else $error("shutdown not asserted");
   lock_holds_a: assert property (!(cfg_wr && !config_lock_i) |-> ##2 $stable(voltage_mode_o))
      else $error("voltage mode changed without write");
   trip_blocks_a: assert property (cfg_wr && !config_lock_i && trip_threshold_pin_i
      |-> ##2 !voltage_mode_o[0])
      else $error("channel 1 mode set in trip mode");
   apd_override_a: assert property (!$past(reset_i) |-> antiparallel_eff_o ==
      ($past(antiparallel_diode_en_i) && !voltage_mode_o[2]))
      else $error("diode mode not overridden");
   gpio_alert_a: assert property (cond_i.gpio_any && !alert_en_i.alert_mask |=> !alert_n_o)
      else $error("pin summary did not alert");
   high_read_a: assert property (cond_i.high[1] ##1 (reg_rd_i && reg_addr_i == ADDR_HIGH_STATUS)
      |=> reg_rdata_o[1])
      else $error("persistent high bit lost");
   die_read_a: assert property (cond_i.die_shutdown ##1 sum_rd |=> reg_rdata_o[SUM_DIE])
      else $error("die flag not reported");
endmodule : status_monitor
`default_nettype wire

// ==== host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************
// host register master
// ************
module host_model (
   input  wire logic       clk_i,    // clock
   output var  logic [7:0] addr_o,   // offset
   output var  logic       wr_o,     // write strobe
   output var  logic [7:0] wdata_o,  // write data
   output var  logic       rd_o,     // read strobe
   input  wire logic [7:0] rdata_i,  // read data
   input  wire logic       rvalid_i  // read valid
);
   initial begin
      addr_o = 8'hff;
      wr_o = 1'b0;
      wdata_o = 8'h00;
      rd_o = 1'b0;
   end
   // idle lines show the inverse so stale values never look valid
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask : write_reg
   // data is taken while the one-cycle valid stands
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(negedge clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
      ok = rvalid_i;
   endtask : read_reg
endmodule : host_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import monitor_alert_pkg::*;
   logic clk_sys_i, reset_i, wr, rd, rvalid, lock, trip, antiparallel_diode_en, apd_eff, sd_n, al_n;
   logic [7:0] addr, wdata, rdata;
   logic [3:0][7:0] vin, vout;
   logic [2:0] vmode;
   alert_enable_type en;
   monitor_cond_type cond;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;

   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   // short ticks keep the four and two second counts brief
   monitor_status_alert_aggregator #(.TICK_CYCLES_P(4), .WATCHDOG_TICKS_P(5),
      .OVERCUR_TICKS_P(3)) u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .config_lock_i(lock),
      .trip_threshold_pin_i(trip), .antiparallel_diode_en_i(antiparallel_diode_en), .alert_en_i(en),
      .cond_i(cond), .vin_raw_i(vin), .vin_value_o(vout), .voltage_mode_o(vmode),
      .antiparallel_eff_o(apd_eff), .shutdown_out_n_o(sd_n), .alert_n_o(al_n));
   host_model u_host (.clk_i(clk_sys_i), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
      .rd_o(rd), .rdata_i(rdata), .rvalid_i(rvalid));

   // ************
   // helpers
   // ************
   task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   task automatic bchk(input string w, input logic e, input logic g);
      chk(w, {7'h00, e}, {7'h00, g});
   endtask : bchk
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      u_host.read_reg(a, d, ok);
      bchk("rvalid", 1'b1, ok);
      chk($sformatf("reg %h", a), e, d);
   endtask : rchk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : cyc
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   // ************
   // scenarios
   // ************
   task automatic t_reset();
      logic [7:0] ra [8];
      ra = '{ADDR_CRIT_STATUS, ADDR_VCH_CONFIG, ADDR_INT_SUMMARY, ADDR_HIGH_STATUS,
         ADDR_LOW_STATUS, ADDR_FAULT_STAT, ADDR_FAN_STATUS, 8'h30};
      bchk("alert_n", 1'b1, al_n);
      foreach (ra[i]) rchk(ra[i], 8'h00);
      cyc(20);
      cond.fan_programmed = 1'b1;
      cyc(1);
      cond.fan_programmed = 1'b0;
      bchk("alert_n", 1'b0, al_n);
      rchk(ADDR_INT_SUMMARY, 8'h08);
      rchk(ADDR_FAN_STATUS, 8'h80);
      rchk(ADDR_FAN_STATUS, 8'h00);
      bchk("alert_n", 1'b1, al_n);
   endtask : t_reset
   task automatic t_config();
      antiparallel_diode_en = 1'b1;
      u_host.write_reg(ADDR_VCH_CONFIG, 8'hff);
      cyc(3);
      rchk(ADDR_VCH_CONFIG, 8'h7f);
      chk("vmode", 8'h07, {5'h00, vmode});
      bchk("apd_eff", 1'b0, apd_eff);
      for (int i = 0; i < 4; i++) chk("vin inv", 8'hff - vin[i], vout[i]);
      u_host.write_reg(ADDR_VCH_CONFIG, 8'h00);
      cyc(3);
      bchk("apd_eff", 1'b1, apd_eff);
      for (int i = 0; i < 4; i++) chk("vin raw", vin[i], vout[i]);
      trip = 1'b1;
      u_host.write_reg(ADDR_VCH_CONFIG, 8'hff);
      lock = 1'b1;
      u_host.write_reg(ADDR_VCH_CONFIG, 8'h00);
      cyc(3);
      rchk(ADDR_VCH_CONFIG, 8'h3c);
      chk("vin ch4", vin[3], vout[3]);
      lock = 1'b0;
      trip = 1'b0;
   endtask : t_config
   task automatic t_status();
      logic [7:0] ra [3];
      ra = '{ADDR_HIGH_STATUS, ADDR_LOW_STATUS, ADDR_FAULT_STAT};
      rchk(ADDR_FAULT_STAT, 8'h00);
      en.chan_en = 6'h3f;
      for (int i = 0; i < 3; i++) begin
         cond.high[1] = (i == 0);
         cond.low[1] = (i == 1);
         cond.fault[0] = (i == 2);
         cyc(2);
         cond = '0;
         cyc(2);
         bchk("alert_n", 1'b0, al_n);
         rchk(ADDR_INT_SUMMARY, 8'(8'h04 >> i));
         rchk(ADDR_INT_SUMMARY, 8'(8'h04 >> i));
         rchk(ra[i], 8'h02);
         rchk(ra[i], 8'h00);
         rchk(ADDR_INT_SUMMARY, 8'h00);
         bchk("alert_n", 1'b1, al_n);
      end
      cond.high[1] = 1'b1;
      cyc(2);
      rchk(ADDR_HIGH_STATUS, 8'h02);
      cond.high[1] = 1'b0;
      rchk(ADDR_HIGH_STATUS, 8'h02);
      rchk(ADDR_HIGH_STATUS, 8'h00);
      u_host.write_reg(ADDR_VCH_CONFIG, 8'h02);
      cyc(2);
      cond.fault[0] = 1'b1;
      cond.high[1] = 1'b1;
      cyc(2);
      cond = '0;
      rchk(ADDR_FAULT_STAT, 8'h00);
      rchk(ADDR_HIGH_STATUS, 8'h02);
      u_host.write_reg(ADDR_VCH_CONFIG, 8'h00);
      en.chan_en = 6'h00;
      cond.high[1] = 1'b1;
      cyc(2);
      cond = '0;
      cyc(2);
      bchk("alert_n", 1'b1, al_n);
      rchk(ADDR_HIGH_STATUS, 8'h02);
      en.chan_en = 6'h3f;
      en.alert_mask = 1'b1;
      cond.high[1] = 1'b1;
      cyc(2);
      cond = '0;
      cyc(2);
      bchk("alert_n", 1'b1, al_n);
      en.alert_mask = 1'b0;
      cyc(2);
      bchk("alert_n", 1'b0, al_n);
      rchk(ADDR_HIGH_STATUS, 8'h02);
      en.chan_en = 6'h00;
   endtask : t_status
   task automatic t_events();
      cond.loader_error = 1'b1;
      cyc(1);
      cond.loader_error = 1'b0;
      cyc(2);
      bchk("alert_n", 1'b0, al_n);
      rchk(ADDR_INT_SUMMARY, 8'h80);
      rchk(ADDR_INT_SUMMARY, 8'h00);
      cond.die_shutdown = 1'b1;
      cyc(3);
      bchk("shutdown_n", 1'b0, sd_n);
      bchk("alert_n", 1'b1, al_n);
      rchk(ADDR_INT_SUMMARY, 8'h40);
      cond.die_shutdown = 1'b0;
      rchk(ADDR_INT_SUMMARY, 8'h40);
      rchk(ADDR_INT_SUMMARY, 8'h00);
      bchk("shutdown_n", 1'b1, sd_n);
      cond.crit[1] = 1'b1;
      cyc(2);
      rchk(ADDR_CRIT_STATUS, 8'h00);
      cond.crit_link[1] = 1'b1;
      cyc(2);
      cond.crit[1] = 1'b0;
      rchk(ADDR_INT_SUMMARY, 8'h20);
      rchk(ADDR_CRIT_STATUS, 8'h02);
      rchk(ADDR_INT_SUMMARY, 8'h00);
      cond.hw_trip = 1'b1;
      cyc(2);
      cond.hw_trip = 1'b0;
      rchk(ADDR_CRIT_STATUS, 8'h80);
      rchk(ADDR_CRIT_STATUS, 8'h00);
      cond.gpio_any = 1'b1;
      cyc(3);
      bchk("alert_n", 1'b0, al_n);
      rchk(ADDR_INT_SUMMARY, 8'h10);
      cond = '0;
   endtask : t_events
   task automatic t_fans();
      logic [7:0] fb [6];
      fb = '{8'h40, 8'h20, 8'h08, 8'h04, 8'h02, 8'h01};
      foreach (fb[i]) begin
         en.fan_spin_en = 2'b00;
         en.fan_stall_en = 2'b00;
         cond.drive_limit = {fb[i][6], fb[i][5]};
         cond.spinup_timeout = {fb[i][3], fb[i][1]};
         cond.stalled = {fb[i][2], fb[i][0]};
         cyc(3);
         bchk("alert_n", 1'b1, al_n);
         en.fan_spin_en = 2'b11;
         en.fan_stall_en = 2'b11;
         cyc(2);
         bchk("alert_n", 1'b0, al_n);
         rchk(ADDR_FAN_STATUS, fb[i]);
         cond = '0;
         rchk(ADDR_FAN_STATUS, fb[i]);
         rchk(ADDR_FAN_STATUS, 8'h00);
      end
      cond.overcurrent = 1'b1;
      cyc(6);
      cond.overcurrent = 1'b0;
      rchk(ADDR_FAN_STATUS, 8'h00);
      cond.overcurrent = 1'b1;
      cyc(30);
      cond.overcurrent = 1'b0;
      rchk(ADDR_FAN_STATUS, 8'h10);
      rchk(ADDR_FAN_STATUS, 8'h00);
   endtask : t_fans

   initial begin
      reset_i = 1'b1;
      lock = 1'b0;
      trip = 1'b0;
      antiparallel_diode_en = 1'b0;
      en = '0;
      cond = '0;
      vin = {8'h40, 8'h30, 8'h20, 8'h10};
      cyc(2);
      reset_i = 1'b0;
      t_reset();
      t_config();
      t_status();
      t_events();
      t_fans();
      results();
   end
   // hang guard
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         results();
      end
   end
endmodule : testbench

bind monitor_status_alert_aggregator status_monitor u_mon (.clk_sys_i(clk_sys_i),
   .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .reg_rvalid_o(reg_rvalid_o), .config_lock_i(config_lock_i),
   .trip_threshold_pin_i(trip_threshold_pin_i),
   .antiparallel_diode_en_i(antiparallel_diode_en_i), .alert_en_i(alert_en_i),
   .cond_i(cond_i), .vin_raw_i(vin_raw_i), .vin_value_o(vin_value_o),
   .voltage_mode_o(voltage_mode_o), .antiparallel_eff_o(antiparallel_eff_o),
   .shutdown_out_n_o(shutdown_out_n_o), .alert_n_o(alert_n_o));
`default_nettype wire
